// ### design/macc_pkg.sv
/*
  Shared constants and carrier type for the clock and analog configuration
  register bank: byte addresses, field positions, reset values and the
  serial frame layout.
  Assumes a byte-wide register space reached over a 4-wire serial port.
*/
package macc_pkg;

  // ***************************************************
  // register addresses (15-bit serial address space)
  // ***************************************************
  localparam logic [14:0] ADDR_CLK_CTRL0    = 15'h0029;
  localparam logic [14:0] ADDR_CLK_INPUT    = 15'h002A;
  localparam logic [14:0] ADDR_POS_B0       = 15'h002C;
  localparam logic [14:0] ADDR_POS_B1       = 15'h002D;
  localparam logic [14:0] ADDR_POS_B2       = 15'h002E;
  localparam logic [14:0] ADDR_FS_A_LO      = 15'h0030;
  localparam logic [14:0] ADDR_FS_A_HI      = 15'h0031;
  localparam logic [14:0] ADDR_FS_B_LO      = 15'h0032;
  localparam logic [14:0] ADDR_FS_B_HI      = 15'h0033;
  localparam logic [14:0] ADDR_REF_BYPASS   = 15'h0038;
  localparam logic [14:0] ADDR_TS_CONTROL   = 15'h003B;
  localparam logic [14:0] ADDR_SER_PREEMPH  = 15'h0048;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int BIT_DEV_CK_PECL   = 2;
  localparam int BIT_SYSREF_PECL   = 1;
  localparam int BIT_SYSREF_INV    = 0;
  localparam int BIT_MAGNIFY       = 4;
  localparam int BIT_REF_BYPASS    = 0;
  localparam int BIT_TS_PECL_EN    = 1;
  localparam int BIT_TS_RECV_EN    = 0;

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [15:0] RST_FULL_SCALE = 16'hA000;
  localparam logic [23:0] RST_POSITION   = 24'h000000;

  // ***************************************************
  // serial frame: r/w bit, 15 address bits, then data bytes
  // ***************************************************
  localparam logic [4:0] CNT_HDR_LAST  = 5'h0F;
  localparam logic [4:0] CNT_DATA_FST  = 5'h10;
  localparam logic [4:0] CNT_DATA_LAST = 5'h17;
  localparam int         PIN_SCLK      = 0;
  localparam int         PIN_CSB       = 1;
  localparam int         PIN_SDI       = 2;
  localparam int         PIN_SYSREF    = 3;
  localparam int         LANES_DEF     = 16;

  typedef struct packed {
    logic        devclock_pecl_mode_en;
    logic        sysref_pecl_mode_en;
    logic        sysref_polarity_invert;
    logic        sysref_strobe_magnify;
    logic [3:0]  sysref_delay_select;
    logic        reference_bypass_sel;
    logic        timestamp_receiver_en;
    logic        timestamp_pecl_mode_en;
    logic [3:0]  lane_preemphasis_code;
    logic [15:0] input_a_full_scale_code;
    logic [15:0] input_b_full_scale_code;
  } macc_cfg_t;

endpackage

// ### design/macc_regs.sv
/*
  Clock, reference, timestamp and serializer configuration register bank
  with its serial register port slave.
  Assumes the serial port pins are asynchronous to clk_sys_in and that the
  serial clock runs well below a tenth of it; the edge position word comes
  from logic on clk_sys_in.
*/
`timescale 1ns/1ps
module macc_regs
  import macc_pkg::*;
#(
  parameter int LANES = LANES_DEF
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  spi_sclk_in,
  input  wire logic                  spi_csb_n_in,
  input  wire logic                  spi_sdi_in,
  output logic                       spi_sdo_out,
  output logic                       spi_sdo_oe_out,
  input  wire logic                  sysref_raw_in,
  input  wire logic [23:0]           sysref_edge_position_in,
  output macc_cfg_t                  cfg_out,
  output logic                       sysref_auto_cal_out,
  output logic                       sysref_aligned_out,
  output logic [LANES-1:0][3:0]      lane_preemphasis_out
);

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [3:0]  pin_s1_r;
  logic [3:0]  pin_s2_r;
  logic        sclk_d_r;
  logic        csb_d_r;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1_r <= 4'h2;
      pin_s2_r <= 4'h2;
      sclk_d_r <= 1'b0;
      csb_d_r  <= 1'b1;
    end else begin
      pin_s1_r <= {sysref_raw_in, spi_sdi_in, spi_csb_n_in, spi_sclk_in};
      pin_s2_r <= pin_s1_r;
      sclk_d_r <= pin_s2_r[PIN_SCLK];
      csb_d_r  <= pin_s2_r[PIN_CSB];
    end
  end

  logic sclk_rise;
  logic csb_fall;
  logic sdi;
  assign sclk_rise = pin_s2_r[PIN_SCLK] & ~sclk_d_r & ~pin_s2_r[PIN_CSB];
  assign csb_fall  = csb_d_r & ~pin_s2_r[PIN_CSB];
  assign sdi       = pin_s2_r[PIN_SDI];

  // ***************************************************
  // serial frame tracking
  // ***************************************************
  logic [4:0]  cnt_r;
  logic [15:0] hdr_r;
  logic [7:0]  dsh_r;
  logic [7:0]  rdsh_r;
  logic [14:0] addr_r;
  logic        rd_r;
  logic        hdr_done;
  logic        byte_done;
  logic        in_data;
  logic [15:0] hdr_word;
  logic        wr_en;
  logic [7:0]  wr_data;

  assign in_data   = cnt_r >= CNT_DATA_FST;
  assign hdr_done  = sclk_rise && (cnt_r == CNT_HDR_LAST);
  assign byte_done = sclk_rise && (cnt_r == CNT_DATA_LAST);
  assign hdr_word  = {hdr_r[14:0], sdi};
  assign wr_data   = {dsh_r[6:0], sdi};
  assign wr_en     = byte_done & ~rd_r;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 5'h00;
    end else if (pin_s2_r[PIN_CSB]) begin
      cnt_r <= 5'h00;
    end else if (sclk_rise) begin
      // streaming: wrap back into the data phase for the next byte
      cnt_r <= (cnt_r == CNT_DATA_LAST) ? CNT_DATA_FST : cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hdr_r <= 16'h0000;
      dsh_r <= 8'h00;
    end else if (sclk_rise) begin
      if (in_data) begin
        dsh_r <= wr_data;
      end else begin
        hdr_r <= hdr_word;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_r   <= 1'b0;
      addr_r <= 15'h0000;
    end else if (pin_s2_r[PIN_CSB]) begin
      rd_r <= 1'b0;
    end else if (hdr_done) begin
      rd_r   <= hdr_word[15];
      addr_r <= hdr_word[14:0];
    end else if (byte_done) begin
      addr_r <= addr_r + 15'h0001;
    end
  end

  // ***************************************************
  // configuration registers, full bytes kept so reserved bits read back
  // ***************************************************
  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic [15:0] fsa_r;
  logic [15:0] fsb_r;
  logic [7:0]  bgb_r;
  logic [7:0]  tms_r;
  logic [7:0]  spe_r;
  logic [23:0] pos_r;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl0_r <= RST_BYTE;
      ctrl1_r <= RST_BYTE;
    end else if (wr_en) begin
      if (addr_r == ADDR_CLK_CTRL0) ctrl0_r <= wr_data;
      if (addr_r == ADDR_CLK_INPUT) ctrl1_r <= wr_data;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fsa_r <= RST_FULL_SCALE;
      fsb_r <= RST_FULL_SCALE;
    end else if (wr_en) begin
      // codes below the recommended floor are taken as written
      if (addr_r == ADDR_FS_A_LO) fsa_r[7:0]  <= wr_data;
      if (addr_r == ADDR_FS_A_HI) fsa_r[15:8] <= wr_data;
      if (addr_r == ADDR_FS_B_LO) fsb_r[7:0]  <= wr_data;
      if (addr_r == ADDR_FS_B_HI) fsb_r[15:8] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bgb_r <= RST_BYTE;
      tms_r <= RST_BYTE;
      spe_r <= RST_BYTE;
    end else if (wr_en) begin
      if (addr_r == ADDR_REF_BYPASS)  bgb_r <= wr_data;
      if (addr_r == ADDR_TS_CONTROL)  tms_r <= wr_data;
      if (addr_r == ADDR_SER_PREEMPH) spe_r <= wr_data;
    end
  end

  // snapshot at frame start so a streamed 3-byte read never tears
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_r <= RST_POSITION;
    end else if (csb_fall) begin
      pos_r <= sysref_edge_position_in;
    end
  end

  // ***************************************************
  // read path
  // ***************************************************
  function automatic logic [7:0] read_byte(input logic [14:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_CLK_CTRL0:   v = ctrl0_r;
      ADDR_CLK_INPUT:   v = ctrl1_r;
      ADDR_POS_B0:      v = pos_r[7:0];
      ADDR_POS_B1:      v = pos_r[15:8];
      ADDR_POS_B2:      v = pos_r[23:16];
      ADDR_FS_A_LO:     v = fsa_r[7:0];
      ADDR_FS_A_HI:     v = fsa_r[15:8];
      ADDR_FS_B_LO:     v = fsb_r[7:0];
      ADDR_FS_B_HI:     v = fsb_r[15:8];
      ADDR_REF_BYPASS:  v = bgb_r;
      ADDR_TS_CONTROL:  v = tms_r;
      ADDR_SER_PREEMPH: v = spe_r;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdsh_r <= 8'h00;
    end else if (hdr_done) begin
      rdsh_r <= read_byte(hdr_word[14:0]);
    end else if (byte_done) begin
      rdsh_r <= read_byte(addr_r + 15'h0001);
    end else if (sclk_rise && in_data) begin
      rdsh_r <= {rdsh_r[6:0], 1'b0};
    end
  end

  assign spi_sdo_out    = rdsh_r[7];
  assign spi_sdo_oe_out = rd_r & in_data & ~pin_s2_r[PIN_CSB];

  // ***************************************************
  // outputs to the analog and alignment logic
  // ***************************************************
  always_comb begin
    cfg_out.devclock_pecl_mode_en   = ctrl1_r[BIT_DEV_CK_PECL];
    cfg_out.sysref_pecl_mode_en     = ctrl1_r[BIT_SYSREF_PECL];
    cfg_out.sysref_polarity_invert  = ctrl1_r[BIT_SYSREF_INV];
    cfg_out.sysref_strobe_magnify   = ctrl0_r[BIT_MAGNIFY];
    cfg_out.sysref_delay_select     = ctrl0_r[3:0];
    cfg_out.reference_bypass_sel    = bgb_r[BIT_REF_BYPASS];
    cfg_out.timestamp_receiver_en   = tms_r[BIT_TS_RECV_EN];
    cfg_out.timestamp_pecl_mode_en  = tms_r[BIT_TS_PECL_EN];
    cfg_out.lane_preemphasis_code   = spe_r[3:0];
    cfg_out.input_a_full_scale_code = fsa_r;
    cfg_out.input_b_full_scale_code = fsb_r;
  end

  assign sysref_auto_cal_out = (ctrl0_r[3:0] == 4'h0);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sysref_aligned_out <= 1'b0;
    end else begin
      sysref_aligned_out <= pin_s2_r[PIN_SYSREF] ^ ctrl1_r[BIT_SYSREF_INV];
    end
  end

  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      assign lane_preemphasis_out[gl] = spe_r[3:0];
    end
  endgenerate

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence wr_ctrl1_s;
    wr_en && (addr_r == ADDR_CLK_INPUT);
  endsequence
  sequence wr_ctrl0_s;
    wr_en && (addr_r == ADDR_CLK_CTRL0);
  endsequence

  device_sample_clock_pecl_a: assert property (wr_ctrl1_s |=> cfg_out.devclock_pecl_mode_en == $past(wr_data[2]))
    else $error("device clock mode bit not taken from write");
  sysref_pecl_a: assert property (wr_ctrl1_s |=> cfg_out.sysref_pecl_mode_en == $past(wr_data[1]))
    else $error("alignment input mode bit not taken from write");
  polarity_path_a: assert property (sysref_aligned_out == ($past(pin_s2_r[3]) ^ $past(ctrl1_r[0])))
    else $error("alignment signal polarity wrong");
  pos_snapshot_a: assert property (csb_fall |=> pos_r == $past(sysref_edge_position_in))
    else $error("edge position not captured at frame start");
  fs_a_low_a: assert property (wr_en && addr_r == ADDR_FS_A_LO |=> fsa_r[7:0] == $past(wr_data))
    else $error("input A low byte not written");
  fs_b_high_a: assert property (wr_en && addr_r == ADDR_FS_B_HI |=> fsb_r[15:8] == $past(wr_data) ##1 $stable(fsb_r) [*2])
    else $error("input B high byte not held");
  ref_bypass_a: assert property (wr_en && addr_r == ADDR_REF_BYPASS |=> cfg_out.reference_bypass_sel == $past(wr_data[0]))
    else $error("reference bypass not taken");
  timestamp_input_control_a: assert property (wr_en && addr_r == ADDR_TS_CONTROL |=> {cfg_out.timestamp_pecl_mode_en, cfg_out.timestamp_receiver_en} == $past(wr_data[1:0]))
    else $error("timestamp control not taken");
  preemph_code_a: assert property (wr_en && addr_r == ADDR_SER_PREEMPH |=> cfg_out.lane_preemphasis_code == $past(wr_data[3:0]))
    else $error("pre-emphasis code not taken");
  lanes_equal_a: assert property (lane_preemphasis_out == {LANES{cfg_out.lane_preemphasis_code}})
    else $error("lanes disagree on pre-emphasis");
  auto_cal_a: assert property (wr_ctrl0_s |=> sysref_auto_cal_out == ($past(wr_data[3:0]) == 4'h0))
    else $error("automatic calibration select wrong");
  magnify_bit_a: assert property (wr_ctrl0_s |=> cfg_out.sysref_strobe_magnify == $past(wr_data[4]))
    else $error("magnify bit not taken");
  reserved_keep_a: assert property (wr_ctrl1_s |=> ctrl1_r == $past(wr_data) && $stable(ctrl0_r))
    else $error("reserved bits not stored");

endmodule

// ### tb/macc_host_model.sv
/*
  Host side of the serial register port: frames of r/w bit, 15 address
  bits and data bytes, msb first, streaming over consecutive addresses.
  Assumes clk_sys_in is the device system clock and that the bench calls
  xfer from a single process; each read byte is shown for one clock.
*/
`timescale 1ns/1ps
module macc_host_model
  import macc_pkg::*;
(
  input  wire logic       clk_sys_in,
  output logic            sclk_out,
  output logic            csb_n_out,
  output logic            sdi_out,
  input  wire logic       sdo_in,
  input  wire logic       sdo_oe_in,
  output logic [7:0]      rd_data_out,
  output logic            rd_valid_out
);
  // half period of 6 clocks keeps well clear of the 4-clock minimum
  localparam int HALF = 6;

  initial begin
    sclk_out     = 1'b0;
    csb_n_out    = 1'b1;
    sdi_out      = 1'b0;
    rd_data_out  = 8'h00;
    rd_valid_out = 1'b0;
  end

  // ***************************************************
  // bit and frame tasks
  // ***************************************************
  task automatic shift_bit(input logic b, output logic seen);
    sdi_out  <= b;
    sclk_out <= 1'b0;
    repeat (HALF) @(posedge clk_sys_in);
    // undriven sdo must never pass as data
    seen = sdo_oe_in ? sdo_in : 1'bx;
    sclk_out <= 1'b1;
    repeat (HALF) @(posedge clk_sys_in);
  endtask

  task automatic xfer(input logic rd, input logic [14:0] addr, input int nbytes, input logic [31:0] wdata);
    logic [15:0] hdr;
    logic [7:0]  b;
    logic        s;
    hdr = {rd, addr};
    csb_n_out <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    for (int i = 15; i >= 0; i--) begin
      shift_bit(hdr[i], s);
    end
    for (int k = 0; k < nbytes; k++) begin
      for (int i = 7; i >= 0; i--) begin
        shift_bit(wdata[8*k+i], s);
        b[i] = s;
      end
      if (rd) begin
        rd_data_out  <= b;
        rd_valid_out <= 1'b1;
        @(posedge clk_sys_in);
        rd_valid_out <= 1'b0;
      end
    end
    // released data line toggles so a stale level is never trusted
    sclk_out  <= 1'b0;
    csb_n_out <= 1'b1;
    sdi_out   <= ~sdi_out;
    repeat (8) @(posedge clk_sys_in);
  endtask
endmodule

// ### tb/misc_analog_clock_config_regs_tb_top.sv
/*
  Self-checking bench for the configuration register bank: register
  access through the host model, config outputs, alignment path, lanes.
  Assumes the host model file and macc_pkg are compiled first.
*/
`timescale 1ns/1ps
module misc_analog_clock_config_regs_tb_top;
  import macc_pkg::*;
  logic                  clk_sys_in;
  logic                  rst_n_in;
  logic                  sysref_raw_in;
  logic [23:0]           sysref_edge_position_in;
  logic                  sclk;
  logic                  csb_n;
  logic                  sdi;
  logic                  sdo;
  logic                  sdo_oe;
  logic [7:0]            rd_data;
  logic                  rd_valid;
  macc_cfg_t             cfg;
  logic                  auto_cal;
  logic                  aligned;
  logic [15:0][3:0]      lanes;
  logic [7:0]            exp_q[$];
  logic [31:0]           seed;
  int                    miscompares;
  int                    check_count;

  macc_regs #(.LANES(16)) macc_regs_i (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .spi_sclk_in(sclk), .spi_csb_n_in(csb_n),
    .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe), .sysref_raw_in(sysref_raw_in),
    .sysref_edge_position_in(sysref_edge_position_in), .cfg_out(cfg), .sysref_auto_cal_out(auto_cal),
    .sysref_aligned_out(aligned), .lane_preemphasis_out(lanes));

  macc_host_model macc_host_model_i (
    .clk_sys_in(clk_sys_in), .sclk_out(sclk), .csb_n_out(csb_n), .sdi_out(sdi), .sdo_in(sdo),
    .sdo_oe_in(sdo_oe), .rd_data_out(rd_data), .rd_valid_out(rd_valid));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // ***************************************************
  // helpers
  // ***************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [14:0] a, input int n, input logic [31:0] e);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e[8*i+:8]);
    end
    macc_host_model_i.xfer(1'b1, a, n, 32'h0);
  endtask

  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    macc_host_model_i.xfer(1'b0, a, n, d);
  endtask

  task automatic reset_and_check();
    macc_cfg_t rc;
    rc = '0;
    rc.input_a_full_scale_code = RST_FULL_SCALE;
    rc.input_b_full_scale_code = RST_FULL_SCALE;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    check(cfg, rc);
    check(auto_cal, 1'b1);
    check(lanes, 64'h0);
    rd(ADDR_FS_A_LO, 4, 32'hA000A000);
    rd(ADDR_CLK_INPUT, 1, 32'h0);
    rd(ADDR_REF_BYPASS, 1, 32'h0);
    rd(ADDR_TS_CONTROL, 1, 32'h0);
    rd(ADDR_SER_PREEMPH, 1, 32'h0);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ***************************************************
  // read monitor and watchdog
  // ***************************************************
  always @(posedge clk_sys_in) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(rd_data, 64'hFFFF);
      end else begin
        check(rd_data, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk_sys_in);
    miscompares++;
    tally_and_finish();
  end

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    logic [31:0] e;
    logic [15:0] fa;
    logic [15:0] fb;
    logic [23:0] p;
    miscompares = 0;
    check_count = 0;
    seed = 32'h0000004F;
    rst_n_in = 1'b0;
    sysref_raw_in = 1'b0;
    sysref_edge_position_in = 24'h000000;
    reset_and_check();
    for (int k = 0; k < 3; k++) begin
      a = rnd();
      b = rnd();
      c = rnd();
      d = rnd();
      e = rnd();
      if (k == 0) e[3:0] = 4'h0;
      fa = 16'h2000 + 16'(rnd() % 32'd57344);
      fb = 16'h2000 + 16'(rnd() % 32'd57344);
      wr(ADDR_CLK_INPUT, 1, a);
      wr(ADDR_REF_BYPASS, 1, b);
      wr(ADDR_TS_CONTROL, 1, c);
      wr(ADDR_SER_PREEMPH, 1, d);
      wr(ADDR_CLK_CTRL0, 1, e);
      wr(ADDR_FS_A_LO, 4, {fb, fa});
      rd(ADDR_CLK_INPUT, 1, a);
      rd(ADDR_REF_BYPASS, 1, b);
      rd(ADDR_TS_CONTROL, 1, c);
      rd(ADDR_SER_PREEMPH, 1, d);
      rd(ADDR_FS_A_LO, 4, {fb, fa});
      check(cfg.devclock_pecl_mode_en, a[2]);
      check(cfg.sysref_pecl_mode_en, a[1]);
      check(cfg.sysref_polarity_invert, a[0]);
      check(cfg.reference_bypass_sel, b[0]);
      check(cfg.timestamp_receiver_en, c[0]);
      check(cfg.timestamp_pecl_mode_en, c[1]);
      check(cfg.lane_preemphasis_code, d[3:0]);
      check(cfg.input_a_full_scale_code, fa);
      check(cfg.input_b_full_scale_code, fb);
      check(cfg.sysref_delay_select, e[3:0]);
      check(auto_cal, e[3:0] == 4'h0);
      check(cfg.sysref_strobe_magnify, e[4]);
      for (int l = 0; l < 16; l++) begin
        check(lanes[l], d[3:0]);
      end
      sysref_raw_in <= b[5];
      repeat (4) @(posedge clk_sys_in);
      check(aligned, b[5] ^ a[0]);
      p = rnd();
      sysref_edge_position_in <= p;
      rd(ADDR_POS_B0, 3, {8'h00, p});
      wr(ADDR_POS_B0, 3, ~p);
      rd(ADDR_POS_B0, 3, {8'h00, p});
      // delay select picked from the captured position
      wr(ADDR_CLK_CTRL0, 1, {28'h0, p[3:0]});
      check(auto_cal, p[3:0] == 4'h0);
    end
    wr(15'h002B, 1, 32'h5A);
    rd(15'h002B, 1, 32'h0);
    reset_and_check();
    for (int i = 0; i < 50 && exp_q.size() != 0; i++) begin
      @(posedge clk_sys_in);
    end
    if (exp_q.size() != 0) miscompares++;
    tally_and_finish();
  end
endmodule
